// *** core/remap_params.svh ***
`ifndef REMAP_PARAMS_SVH
`define REMAP_PARAMS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define ADDR_ENTRY 4'h0
`define ADDR_REQUEST 4'h4
`define ADDR_STATUS 4'h8

// ****************************************************************
// entry word field positions
// ****************************************************************
`define PRESENT_BIT 0
`define TRIG_BIT 4
`define MODE_LO 5
`define MODE_HI 7
`define VEC_LO 16
`define VEC_HI 23

// ****************************************************************
// delivery mode field encodings
// ****************************************************************
`define MODE_FIXED 3'h0
`define MODE_LOWEST 3'h1
`define MODE_SYS_MGMT 3'h2
`define MODE_RSVD_A 3'h3
`define MODE_NMI 3'h4
`define MODE_INIT 3'h5
`define MODE_RSVD_B 3'h6
`define MODE_LEGACY 3'h7

// ****************************************************************
// request and status fields, reset values
// ****************************************************************
`define REQ_GO_BIT 0
`define ST_DELIVER_BIT 0
`define ST_BLOCKED_BIT 1
`define ST_RESERVED_BIT 2
`define ST_LEVEL_BIT 3
`define ST_KIND_LO 4
`define ST_KIND_HI 6
`define ENTRY_RESET 32'h0000_0000
`define STATUS_RESET 32'h0000_0000
`define VEC_ZERO 8'h00

`endif

// *** core/remap_pkg.sv ***
package remap_pkg;

  // decoded kind of delivery for one entry
  typedef enum logic [2:0] {
    KIND_NONE,
    KIND_FIXED,
    KIND_LOWEST,
    KIND_SYS_MGMT,
    KIND_NMI,
    KIND_INIT,
    KIND_LEGACY
  } delivery_kind_type;

  typedef logic [31:0] word_type;

endpackage

// *** core/remap_mode_decoder.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "remap_params.svh"

module remap_mode_decoder
  import remap_pkg::*;
(
  input wire logic [31:0] entry_in,
  output delivery_kind_type kind_out,
  output logic level_out,
  output logic [7:0] vector_out,
  output logic deliver_out,
  output logic blocked_out,
  output logic reserved_out
);

  logic present;
  logic trig;
  logic [2:0] mode;

  // field extraction
  assign present = entry_in[`PRESENT_BIT];
  assign trig = entry_in[`TRIG_BIT];
  assign mode = entry_in[`MODE_HI:`MODE_LO];

  // decode of delivery mode and trigger, only for a present entry
  always_comb begin
    kind_out = KIND_NONE;
    level_out = 1'b0;
    vector_out = `VEC_ZERO;
    deliver_out = 1'b0;
    blocked_out = !present;
    reserved_out = 1'b0;
    if (present) begin
      case (mode)
        `MODE_FIXED: begin
          kind_out = KIND_FIXED;
          level_out = trig;
          vector_out = entry_in[`VEC_HI:`VEC_LO];
          deliver_out = 1'b1;
        end
        `MODE_LOWEST: begin
          kind_out = KIND_LOWEST;
          level_out = trig;
          vector_out = entry_in[`VEC_HI:`VEC_LO];
          deliver_out = 1'b1;
        end
        `MODE_SYS_MGMT: begin
          kind_out = KIND_SYS_MGMT;
          deliver_out = 1'b1;
        end
        `MODE_NMI: begin
          kind_out = KIND_NMI;
          deliver_out = 1'b1;
        end
        `MODE_INIT: begin
          kind_out = KIND_INIT;
          deliver_out = 1'b1;
        end
        `MODE_LEGACY: begin
          kind_out = KIND_LEGACY;
          level_out = trig;
          deliver_out = 1'b1;
        end
        default: begin
          reserved_out = 1'b1;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// *** core/remap_entry_delivery_decode.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "remap_params.svh"

// What this block does
// - mode 000b delivers fixed to all destination agents, edge or level.
// - mode 001b delivers to exactly one destination agent, edge or level.
// - mode 010b is system management, always edge, vector ignored.
// - mode 100b delivers non-maskable to all agents, edge, vector ignored.
// - mode 101b delivers processor init to all agents, edge, no vector.
// - mode 111b delivers to every agent's legacy interrupt input.
// - trigger bit 4: zero is edge, one is level.
// - trigger bit is looked at only when the entry is present.
// - present bit 0 clear blocks requests; set processes them.
module remap_entry_delivery_decode
  import remap_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic [3:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [31:0] writedata_in,
  input wire logic [3:0] byteenable_in,
  output logic [31:0] readdata_out,
  output logic waitrequest_out,
  output logic deliver_out,
  output logic blocked_out,
  output logic reserved_out,
  output logic fixed_out,
  output logic lowest_out,
  output logic system_management_interrupt_out,
  output logic nmi_out,
  output logic init_out,
  output logic legacy_out,
  output logic level_out,
  output logic [7:0] vector_out
);

  // ****************************************************************
  // bus slave
  // ****************************************************************
  logic ack;
  logic next_ack;
  logic next_waitrequest;
  logic [31:0] next_readdata;
  logic wr_commit;
  logic req_fire;
  word_type entry;
  word_type next_entry;
  word_type status;
  word_type next_status;

  // a write lands only at the edge where waitrequest is seen low
  assign wr_commit = ack && write_in;
  assign req_fire = wr_commit && (address_in == `ADDR_REQUEST) &&
                    byteenable_in[0] && writedata_in[`REQ_GO_BIT];

  // one wait cycle per transfer, read data captured before release
  always_comb begin
    next_ack = (read_in || write_in) && !ack;
    next_waitrequest = !next_ack;
    next_readdata = readdata_out;
    if (next_ack && read_in) begin
      case (address_in)
        `ADDR_ENTRY: next_readdata = entry;
        `ADDR_STATUS: next_readdata = status;
        default: next_readdata = 32'h0000_0000; // request and unmapped
      endcase
    end
  end

  // bus handshake registers
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      ack <= 1'b0;
      waitrequest_out <= 1'b1;
      readdata_out <= 32'h0000_0000;
    end else begin
      ack <= next_ack;
      waitrequest_out <= next_waitrequest;
      readdata_out <= next_readdata;
    end
  end

  // ****************************************************************
  // entry register, byte lane writes
  // ****************************************************************
  always_comb begin
    next_entry = entry;
    if (wr_commit && (address_in == `ADDR_ENTRY)) begin
      for (int i = 0; i < 4; i++) begin
        if (byteenable_in[i]) begin
          next_entry[i*8 +: 8] = writedata_in[i*8 +: 8];
        end
      end
    end
  end

  // entry storage
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      entry <= `ENTRY_RESET;
    end else begin
      entry <= next_entry;
    end
  end

  // ****************************************************************
  // decode and delivery
  // ****************************************************************
  delivery_kind_type dec_kind;
  logic dec_level;
  logic [7:0] dec_vector;
  logic dec_deliver;
  logic dec_blocked;
  logic dec_reserved;
  logic next_deliver;
  logic next_blocked;
  logic next_reserved;
  logic next_fixed;
  logic next_lowest;
  logic next_sys_mgmt;
  logic next_nmi;
  logic next_init;
  logic next_legacy;
  logic next_level;
  logic [7:0] next_vector;

  remap_mode_decoder remap_mode_decoder_inst (
    .entry_in(entry),
    .kind_out(dec_kind),
    .level_out(dec_level),
    .vector_out(dec_vector),
    .deliver_out(dec_deliver),
    .blocked_out(dec_blocked),
    .reserved_out(dec_reserved)
  );

  // one-cycle delivery pulses per request, status keeps the last result
  always_comb begin
    next_deliver = req_fire && dec_deliver;
    next_blocked = req_fire && dec_blocked;
    next_reserved = req_fire && dec_reserved;
    next_fixed = req_fire && (dec_kind == KIND_FIXED);
    next_lowest = req_fire && (dec_kind == KIND_LOWEST);
    next_sys_mgmt = req_fire && (dec_kind == KIND_SYS_MGMT);
    next_nmi = req_fire && (dec_kind == KIND_NMI);
    next_init = req_fire && (dec_kind == KIND_INIT);
    next_legacy = req_fire && (dec_kind == KIND_LEGACY);
    next_level = req_fire && dec_level;
    next_vector = req_fire ? dec_vector : `VEC_ZERO;
    next_status = status;
    if (req_fire) begin
      next_status = `STATUS_RESET;
      next_status[`ST_DELIVER_BIT] = dec_deliver;
      next_status[`ST_BLOCKED_BIT] = dec_blocked;
      next_status[`ST_RESERVED_BIT] = dec_reserved;
      next_status[`ST_LEVEL_BIT] = dec_level;
      next_status[`ST_KIND_HI:`ST_KIND_LO] = dec_kind;
    end
  end

  // delivery output registers
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      deliver_out <= 1'b0;
      blocked_out <= 1'b0;
      reserved_out <= 1'b0;
      fixed_out <= 1'b0;
      lowest_out <= 1'b0;
      system_management_interrupt_out <= 1'b0;
      nmi_out <= 1'b0;
      init_out <= 1'b0;
      legacy_out <= 1'b0;
      level_out <= 1'b0;
      vector_out <= `VEC_ZERO;
      status <= `STATUS_RESET;
    end else begin
      deliver_out <= next_deliver;
      blocked_out <= next_blocked;
      reserved_out <= next_reserved;
      fixed_out <= next_fixed;
      lowest_out <= next_lowest;
      system_management_interrupt_out <= next_sys_mgmt;
      nmi_out <= next_nmi;
      init_out <= next_init;
      legacy_out <= next_legacy;
      level_out <= next_level;
      vector_out <= next_vector;
      status <= next_status;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_req(logic [2:0] m);
    req_fire && entry[`PRESENT_BIT] && (entry[`MODE_HI:`MODE_LO] == m);
  endsequence

  sequence s_edge_no_vec;
    deliver_out && !level_out && (vector_out == `VEC_ZERO);
  endsequence

  sequence s_quiet;
    !deliver_out && !blocked_out && !reserved_out;
  endsequence

  AST_FIXED_ALL: assert property (@(posedge clk_sys_in)
    disable iff (!nrst_in) s_req(`MODE_FIXED) |=> fixed_out && deliver_out
    && !lowest_out && vector_out == $past(entry[`VEC_HI:`VEC_LO]) ##1 s_quiet)
    else $error("fixed delivery wrong");

  AST_LOWEST_ONE: assert property (@(posedge clk_sys_in)
    disable iff (!nrst_in) s_req(`MODE_LOWEST) |=> lowest_out && !fixed_out
    && deliver_out && vector_out == $past(entry[`VEC_HI:`VEC_LO]))
    else $error("lowest priority delivery wrong");

  AST_SYS_MGMT_EDGE: assert property (@(posedge clk_sys_in)
    disable iff (!nrst_in) s_req(`MODE_SYS_MGMT)
    |=> system_management_interrupt_out and s_edge_no_vec)
    else $error("system management not edge or vector kept");

  AST_NMI_EDGE: assert property (@(posedge clk_sys_in)
    disable iff (!nrst_in) s_req(`MODE_NMI) |=> nmi_out and s_edge_no_vec)
    else $error("non-maskable not edge or vector kept");

  AST_INIT_EDGE: assert property (@(posedge clk_sys_in)
    disable iff (!nrst_in) s_req(`MODE_INIT) |=> init_out and s_edge_no_vec)
    else $error("init not edge or vector kept");

  AST_LEGACY: assert property (@(posedge clk_sys_in)
    disable iff (!nrst_in) s_req(`MODE_LEGACY) |=> legacy_out && deliver_out
    && !fixed_out && vector_out == `VEC_ZERO)
    else $error("legacy delivery wrong");

  AST_TRIG_LEVEL: assert property (@(posedge clk_sys_in)
    disable iff (!nrst_in) (s_req(`MODE_FIXED) or s_req(`MODE_LOWEST))
    |=> level_out == $past(entry[`TRIG_BIT]))
    else $error("trigger bit not followed");

  AST_TRIG_IGNORED: assert property (@(posedge clk_sys_in)
    disable iff (!nrst_in) req_fire && !entry[`PRESENT_BIT] |=> !level_out)
    else $error("trigger used on absent entry");

  AST_BLOCK: assert property (@(posedge clk_sys_in)
    disable iff (!nrst_in) req_fire && !entry[`PRESENT_BIT] |=> blocked_out
    && !deliver_out && !nmi_out && status[`ST_BLOCKED_BIT] ##1 !blocked_out)
    else $error("absent entry not blocked");

  AST_RESERVED: assert property (@(posedge clk_sys_in)
    disable iff (!nrst_in) (s_req(`MODE_RSVD_A) or s_req(`MODE_RSVD_B))
    |=> reserved_out && !deliver_out && !fixed_out && !legacy_out)
    else $error("reserved mode delivered");

  AST_BUS_ONE_WAIT: assert property (@(posedge clk_sys_in)
    disable iff (!nrst_in) (read_in || write_in) && waitrequest_out
    |=> !waitrequest_out ##1 waitrequest_out)
    else $error("bus answer not one cycle");

endmodule
`default_nettype wire

// *** verification/remap_target_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// receiving agents
// ****************************************************************
module remap_target_model (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic [5:0] kind_in,
  output logic [7:0] taken_out
);
  // count every interrupt that reaches the agents
  always @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      taken_out <= 8'h00;
    end else if (|kind_in) begin
      taken_out <= taken_out + 8'h01;
    end
  end
endmodule
`default_nettype wire

// *** verification/test_remap_entry_delivery_decode.sv ***
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// bench for the entry delivery decoder
// ****************************************************************
module test_remap_entry_delivery_decode;
  import remap_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] address = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [3:0] byteenable = 4'hf;
  logic [31:0] readdata_out;
  logic waitrequest_out, deliver_out, blocked_out, reserved_out, level_out;
  logic fixed_out, lowest_out, sys_mgmt_out, nmi_out, init_out, legacy_out;
  logic [7:0] vector_out, taken;
  logic [17:0] pulses;
  logic [20:0] x;
  logic [31:0] r;
  logic [7:0] vec;
  int n_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  int n_sent = 0;

  assign pulses = {deliver_out, blocked_out, reserved_out, fixed_out,
    lowest_out, sys_mgmt_out, nmi_out, init_out, legacy_out, level_out,
    vector_out};

  remap_entry_delivery_decode remap_entry_delivery_decode_inst (
    .clk_sys_in(clk_sys), .nrst_in(nrst), .address_in(address),
    .read_in(rd), .write_in(wr), .writedata_in(writedata),
    .byteenable_in(byteenable), .readdata_out(readdata_out),
    .waitrequest_out(waitrequest_out), .deliver_out(deliver_out),
    .blocked_out(blocked_out), .reserved_out(reserved_out),
    .fixed_out(fixed_out), .lowest_out(lowest_out),
    .system_management_interrupt_out(sys_mgmt_out),
    .nmi_out(nmi_out), .init_out(init_out), .legacy_out(legacy_out),
    .level_out(level_out), .vector_out(vector_out));

  remap_target_model remap_target_model_inst (
    .clk_sys_in(clk_sys), .nrst_in(nrst), .taken_out(taken),
    .kind_in({fixed_out, lowest_out, sys_mgmt_out, nmi_out, init_out,
      legacy_out}));

  // clock and hang guard
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      end_sim();
    end
  end

  task automatic check(input string name, input logic [31:0] e,
      input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask

  // avalon write, held until waitrequest seen low
  task automatic bus_write(input logic [3:0] a, input logic [31:0] d,
      input logic [3:0] be);
    @(posedge clk_sys);
    address <= a;
    writedata <= d;
    byteenable <= be;
    wr <= 1'b1;
    do @(posedge clk_sys); while (waitrequest_out !== 1'b0);
    wr <= 1'b0;
  endtask

  task automatic bus_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    address <= a;
    rd <= 1'b1;
    do @(posedge clk_sys); while (waitrequest_out !== 1'b0);
    d = readdata_out;
    rd <= 1'b0;
  endtask

  // request one delivery, check the one-cycle pulse
  task automatic fire(input logic [31:0] q, input logic [3:0] be,
      input logic [17:0] e);
    bus_write(4'h4, q, be);
    @(posedge clk_sys);
    check("pulses", {14'h0, e}, {14'h0, pulses});
    @(posedge clk_sys);
    check("pulse_end", 32'h0, {14'h0, pulses});
    if (e[17]) n_sent++;
  endtask

  // expected {kind code, pulses} for one entry
  function automatic logic [20:0] expect_of(input logic [2:0] m,
      input logic t, input logic p, input logic [7:0] v);
    logic [2:0] kc;
    logic lv;
    logic [7:0] vo;
    lv = 1'b0;
    vo = 8'h00;
    case (m)
      3'h0: begin kc = 3'h1; lv = t; vo = v; end
      3'h1: begin kc = 3'h2; lv = t; vo = v; end
      3'h2: kc = 3'h3;
      3'h4: kc = 3'h4;
      3'h5: kc = 3'h5;
      3'h7: begin kc = 3'h6; lv = t; end
      default: kc = 3'h0;
    endcase
    if (!p || kc == 3'h0) begin
      return {3'h0, 1'b0, !p, p, 6'h00, 9'h000};
    end
    return {kc, 3'b100, 6'h20 >> (kc - 3'h1), lv, vo};
  endfunction

  task automatic status_is(input logic [20:0] e);
    bus_read(4'h8, r);
    check("status", {25'h0, e[20:18], e[8], e[15], e[16], e[17]}, r);
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    bus_read(4'h0, r);
    check("entry_reset", 32'h0, r);
    bus_read(4'h8, r);
    check("status_reset", 32'h0, r);
    bus_write(4'h0, 32'hffff_ffff, 4'h5);
    bus_read(4'h0, r);
    check("entry_lanes", 32'h00ff_00ff, r);
    $display("test registers done");
    // every delivery mode with both trigger values
    for (int m = 0; m < 8; m++) begin
      for (int t = 0; t < 2; t++) begin
        vec = (m == 2) ? 8'h00 : 8'h5a;
        bus_write(4'h0, {8'h00, vec, 8'h00, m[2:0], t[0], 4'h1}, 4'hf);
        x = expect_of(m[2:0], t[0], 1'b1, vec);
        fire(32'h1, 4'hf, x[17:0]);
        status_is(x);
      end
    end
    $display("test modes done");
    // entry not present, trigger bit set
    bus_write(4'h0, 32'h005a_0010, 4'hf);
    x = expect_of(3'h0, 1'b1, 1'b0, 8'h5a);
    fire(32'h1, 4'hf, x[17:0]);
    status_is(x);
    fire(32'h0, 4'hf, 18'h0);
    fire(32'h1, 4'he, 18'h0);
    bus_write(4'hc, 32'hffff_ffff, 4'hf);
    bus_write(4'h8, 32'hffff_ffff, 4'hf);
    status_is(x);
    bus_read(4'hc, r);
    check("unmapped", 32'h0, r);
    bus_read(4'h4, r);
    check("request_read", 32'h0, r);
    check("agents_taken", n_sent, {24'h0, taken});
    $display("test blocking done");
    end_sim();
  end
endmodule
`default_nettype wire
